// ---- rtl/ppi_pkg.sv ----
// ppi_pkg: constants for the parallel pixel input and trigger block
package ppi_pkg;
    // ----------------------------------------
    // pixel formats
    // ----------------------------------------
    typedef enum logic [2:0] {
        PPI_FMT_888 = 3'h0,
        PPI_FMT_666 = 3'h1,
        PPI_FMT_565 = 3'h2,
        PPI_FMT_Y422_16 = 3'h3,
        PPI_FMT_SER888 = 3'h4,
        PPI_FMT_SER422 = 3'h5
    } ppi_fmt_t;
    // ----------------------------------------
    // display modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        PPI_MODE_VIDEO = 2'h0,
        PPI_MODE_EXT_PAT = 2'h1,
        PPI_MODE_INT_PAT = 2'h2
    } ppi_mode_t;
    // ----------------------------------------
    // sizes and timing
    // ----------------------------------------
    localparam int PPI_MAX_WIDTH = 1920;
    localparam int PPI_MAX_LINES = 1080;
    localparam int PPI_CLK_MHZ = 250;
    localparam int PPI_SYNC_LOSS_MS = 100;
    localparam int PPI_SYNC_LOSS_CYC = PPI_SYNC_LOSS_MS * PPI_CLK_MHZ * 1000;
    localparam int PPI_PIX_W = 24;
    localparam logic [1:0] PPI_SER888_LAST = 2'h2;
    localparam logic [1:0] PPI_SER422_LAST = 2'h1;
endpackage : ppi_pkg

// ---- rtl/ppi_sync2.sv ----
// ppi_sync2: two-flop synchroniser for a bus of levels
`timescale 1ns/1ns
module ppi_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg; // first stage, read only by o_sync
    // ----------------------------------------
    // two stages
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            meta_reg <= '0;
            o_sync <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule : ppi_sync2

// ---- rtl/ppi_unpack.sv ----
// ppi_unpack: maps one captured bus word onto rgb for the one-clock formats
`timescale 1ns/1ns
module ppi_unpack (
    // format and word
    input wire logic [2:0] i_fmt,
    input wire logic [23:0] i_word,
    input wire logic [7:0] i_chroma_b,
    input wire logic [7:0] i_chroma_r,
    // pixel out
    output logic [23:0] o_pixel
);
    // ----------------------------------------
    // bit placement, narrow fields msb aligned
    // ----------------------------------------
    always_comb begin
        case (ppi_pkg::ppi_fmt_t'(i_fmt))
            ppi_pkg::PPI_FMT_666: o_pixel = {i_word[17:12], 2'h0, i_word[11:6], 2'h0, i_word[5:0], 2'h0};
            ppi_pkg::PPI_FMT_565: o_pixel = {i_word[15:11], 3'h0, i_word[10:5], 2'h0, i_word[4:0], 3'h0};
            ppi_pkg::PPI_FMT_Y422_16: o_pixel = {i_word[15:8], i_chroma_b, i_chroma_r};
            default: o_pixel = i_word;
        endcase
    end
endmodule : ppi_unpack

// ---- rtl/ppi_port.sv ----
// ppi_port: parallel pixel input receiver with frame and pattern triggers
//
// How it works
// - eye flag high means left eye
// - one output frame per input frame
// - lost frame sync stops sequencer, leds off
// - frame and line sync edges configurable
// - inputs captured on pixel clock edge
// - masked frames are not forwarded
// - mask polarity programmable, default active high
// - 888, 666, 565 one-clock formats
// - 16-bit 422 shares chroma over pairs
// - serial 888 takes three clocks
// - serial 422 takes two clocks
// - up to 1920 by 1080 active
// - pattern modes bypass video processing
// - external patterns come over pixel port
// - external mode frame trigger per frame
// - internal mode frame trigger per group
// - pattern trigger during each pattern
// - trigger input only in internal mode
`timescale 1ns/1ns
module ppi_port #(
    parameter int SYNC_LOSS_CYC = ppi_pkg::PPI_SYNC_LOSS_CYC,
    parameter int GROUP_SIZE = 4
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // source pins
    input wire logic i_pixel_clock,
    input wire logic i_frame_sync,
    input wire logic i_line_sync,
    input wire logic i_pixel_valid,
    input wire logic [23:0] i_pixel_bus,
    input wire logic i_frame_update_mask,
    input wire logic i_eye_select,
    input wire logic i_trigger_in,
    // configuration
    input wire logic [2:0] i_cfg_format,
    input wire logic [1:0] i_cfg_mode,
    input wire logic i_cfg_pclk_fall,
    input wire logic i_cfg_fsync_fall,
    input wire logic i_cfg_lsync_fall,
    input wire logic i_cfg_mask_low,
    input wire logic [4:0] i_cfg_pat_per_frame,
    // pixel output
    output logic [23:0] o_pixel,
    output logic o_pixel_stb,
    output logic o_bypass,
    output logic o_frame_start,
    output logic o_line_start,
    output logic o_eye_left,
    output logic [10:0] o_x,
    output logic [10:0] o_y,
    // status and triggers
    output logic o_seq_run,
    output logic o_led_enable,
    output logic o_frame_trigger_out,
    output logic o_pattern_trigger_out,
    output logic o_pattern_adv
);
    // ----------------------------------------
    // input synchronisation
    // ----------------------------------------
    logic [29:0] pins_s; // synchronised pins
    logic pclk_d_reg; // delayed pixel clock
    logic fs_d_reg; // delayed frame sync
    logic ls_d_reg; // delayed line sync
    logic trig_d_reg; // delayed trigger in
    logic pclk_s, fs_s, ls_s, pv_s, mask_s, eye_s, trig_s;
    logic [23:0] bus_s;

    // every pin crosses two flops before use
    ppi_sync2 #(.WIDTH(30)) u_sync (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_async({i_pixel_clock, i_frame_sync, i_line_sync, i_pixel_valid,
                  i_frame_update_mask, i_eye_select, i_trigger_in, i_pixel_bus[22:0]}),
        .o_sync(pins_s)
    );
    // bit 23 rides a second instance to keep widths exact
    logic bus23_s;
    ppi_sync2 #(.WIDTH(1)) u_sync23 (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_async(i_pixel_bus[23]),
        .o_sync(bus23_s)
    );
    assign {pclk_s, fs_s, ls_s, pv_s, mask_s, eye_s, trig_s} = pins_s[29:23];
    assign bus_s = {bus23_s, pins_s[22:0]};

    // ----------------------------------------
    // edge detection
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pclk_d_reg <= 1'b0;
            fs_d_reg <= 1'b0;
            ls_d_reg <= 1'b0;
            trig_d_reg <= 1'b0;
        end else begin
            pclk_d_reg <= pclk_s;
            fs_d_reg <= fs_s;
            ls_d_reg <= ls_s;
            trig_d_reg <= trig_s;
        end
    end

    logic pclk_edge, fs_edge, ls_edge, trig_rise;
    // active pixel clock edge selectable
    assign pclk_edge = i_cfg_pclk_fall ? (pclk_d_reg & ~pclk_s) : (~pclk_d_reg & pclk_s);
    // sync edges selectable by configuration
    assign fs_edge = i_cfg_fsync_fall ? (fs_d_reg & ~fs_s) : (~fs_d_reg & fs_s);
    assign ls_edge = i_cfg_lsync_fall ? (ls_d_reg & ~ls_s) : (~ls_d_reg & ls_s);
    assign trig_rise = ~trig_d_reg & trig_s;

    // ----------------------------------------
    // frame and line state on pixel clock edges
    // ----------------------------------------
    logic masked_reg; // mask latched per frame
    logic eye_reg; // eye latched per frame
    logic line_first_reg; // next valid sample starts a line
    logic frame_first_reg; // next valid sample starts a frame
    logic mask_act;
    // polarity programmable, default active high
    assign mask_act = i_cfg_mask_low ? ~mask_s : mask_s;

    // mask and eye sampled at frame start, so mid-frame mask changes are ignored
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            masked_reg <= 1'b0;
            eye_reg <= 1'b0;
        end else if (fs_edge) begin
            masked_reg <= mask_act;
            eye_reg <= eye_s; // high is left eye
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            line_first_reg <= 1'b1;
            frame_first_reg <= 1'b1;
        end else begin
            if (fs_edge) begin
                frame_first_reg <= 1'b1;
            end else if (pclk_edge && pv_s) begin
                frame_first_reg <= 1'b0;
            end
            if (ls_edge || fs_edge) begin
                line_first_reg <= 1'b1;
            end else if (pclk_edge && pv_s) begin
                line_first_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // serial assembly
    // ----------------------------------------
    logic [1:0] phase_reg; // component index within a pixel
    logic [7:0] c0_reg, c1_reg; // earlier components
    logic [7:0] cb_reg, cr_reg; // held chroma
    logic take; // valid sample this edge
    logic [1:0] phase_now;
    logic [1:0] phase_last;
    assign take = pclk_edge & pv_s;
    assign phase_now = line_first_reg ? 2'h0 : phase_reg;
    assign phase_last = (ppi_pkg::ppi_fmt_t'(i_cfg_format) == ppi_pkg::PPI_FMT_SER888) ?
                        ppi_pkg::PPI_SER888_LAST : ppi_pkg::PPI_SER422_LAST;
    logic serial_fmt;
    assign serial_fmt = (ppi_pkg::ppi_fmt_t'(i_cfg_format) == ppi_pkg::PPI_FMT_SER888) ||
                        (ppi_pkg::ppi_fmt_t'(i_cfg_format) == ppi_pkg::PPI_FMT_SER422);

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            phase_reg <= 2'h0;
            c0_reg <= 8'h00;
            c1_reg <= 8'h00;
        end else if (take) begin
            // three clocks for serial 888, two for serial 422
            phase_reg <= (phase_now == phase_last) ? 2'h0 : phase_now + 2'h1;
            if (phase_now == 2'h0) begin
                c0_reg <= bus_s[7:0];
            end
            if (phase_now == 2'h1) begin
                c1_reg <= bus_s[7:0];
            end
        end
    end

    // 16-bit 422 chroma alternates cb then cr per pixel pair
    logic pair_odd_reg;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pair_odd_reg <= 1'b0;
            cb_reg <= 8'h00;
            cr_reg <= 8'h00;
        end else if (take) begin
            pair_odd_reg <= line_first_reg ? 1'b1 : ~pair_odd_reg;
            if (line_first_reg || !pair_odd_reg) begin
                cb_reg <= bus_s[7:0]; // even pixel carries cb
            end else begin
                cr_reg <= bus_s[7:0]; // odd pixel carries cr
            end
        end
    end

    // ----------------------------------------
    // pixel formation
    // ----------------------------------------
    logic [23:0] par_pix;
    logic [7:0] cb_now;
    assign cb_now = (line_first_reg || !pair_odd_reg) ? bus_s[7:0] : cb_reg;
    ppi_unpack u_unpack (
        .i_fmt(i_cfg_format),
        .i_word(bus_s),
        .i_chroma_b(cb_now),
        .i_chroma_r((line_first_reg || !pair_odd_reg) ? cr_reg : bus_s[7:0]),
        .o_pixel(par_pix)
    ); // one-clock formats

    logic pix_done;
    logic [23:0] pix_word;
    assign pix_done = take && (!serial_fmt || phase_now == phase_last);
    always_comb begin
        if (ppi_pkg::ppi_fmt_t'(i_cfg_format) == ppi_pkg::PPI_FMT_SER888) begin
            pix_word = {c0_reg, c1_reg, bus_s[7:0]};
        end else if (ppi_pkg::ppi_fmt_t'(i_cfg_format) == ppi_pkg::PPI_FMT_SER422) begin
            pix_word = {bus_s[7:0], c0_reg, c0_reg}; // chroma then luma
        end else begin
            pix_word = par_pix;
        end
    end

    // ----------------------------------------
    // coordinate counters, bounded to max size
    // ----------------------------------------
    logic [10:0] x_reg, y_reg;
    logic pix_first_line_reg; // next pixel begins a line
    logic [10:0] x_next; // column of the pixel being formed
    // new line starts at zero, columns stop at the last one
    assign x_next = pix_first_line_reg ? 11'h000 :
                    (x_reg < 11'(ppi_pkg::PPI_MAX_WIDTH - 1)) ? x_reg + 11'h001 : x_reg;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            x_reg <= 11'h000;
            y_reg <= 11'h000;
            pix_first_line_reg <= 1'b1;
        end else begin
            if (fs_edge) begin
                y_reg <= 11'h000;
                pix_first_line_reg <= 1'b1;
            end else if (ls_edge && !pix_first_line_reg) begin
                pix_first_line_reg <= 1'b1;
                if (y_reg < 11'(ppi_pkg::PPI_MAX_LINES - 1)) begin
                    y_reg <= y_reg + 11'h001;
                end
            end else if (pix_done) begin
                pix_first_line_reg <= 1'b0;
            end
            if (pix_done) begin
                x_reg <= x_next;
            end
        end
    end

    // ----------------------------------------
    // output stage
    // ----------------------------------------
    logic pat_mode;
    assign pat_mode = i_cfg_mode != 2'(ppi_pkg::PPI_MODE_VIDEO);
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_pixel <= 24'h000000;
            o_pixel_stb <= 1'b0;
            o_frame_start <= 1'b0;
            o_line_start <= 1'b0;
            o_eye_left <= 1'b0;
            o_bypass <= 1'b0;
            o_x <= 11'h000;
            o_y <= 11'h000;
        end else begin
            // masked frames keep the last shown image
            o_pixel_stb <= pix_done && !masked_reg;
            if (pix_done && !masked_reg) begin
                o_pixel <= pix_word;
                o_x <= x_next;
                o_y <= y_reg;
            end
            // one display frame per input frame, eye tagged
            o_frame_start <= fs_edge;
            o_line_start <= ls_edge;
            o_eye_left <= eye_reg;
            o_bypass <= pat_mode; // pattern data skips video path
        end
    end

    // ----------------------------------------
    // frame sync watchdog
    // ----------------------------------------
    localparam int LW = $clog2(SYNC_LOSS_CYC + 1);
    logic [LW-1:0] loss_cnt_reg;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            loss_cnt_reg <= '0;
            o_seq_run <= 1'b0;
            o_led_enable <= 1'b0;
        end else if (fs_edge) begin
            loss_cnt_reg <= '0;
            o_seq_run <= 1'b1;
            o_led_enable <= 1'b1;
        end else if (loss_cnt_reg == LW'(SYNC_LOSS_CYC)) begin
            o_seq_run <= 1'b0; // sequencer halts on lost sync
            o_led_enable <= 1'b0; // leds off
        end else begin
            loss_cnt_reg <= loss_cnt_reg + LW'(1);
        end
    end

    // ----------------------------------------
    // triggers
    // ----------------------------------------
    logic [4:0] pat_left_reg; // patterns still to show in frame
    logic [7:0] grp_cnt_reg; // internal patterns into group
    logic ext_mode, int_mode, int_adv;
    assign ext_mode = i_cfg_mode == 2'(ppi_pkg::PPI_MODE_EXT_PAT);
    assign int_mode = i_cfg_mode == 2'(ppi_pkg::PPI_MODE_INT_PAT);
    assign int_adv = int_mode && trig_rise; // ignored outside internal

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_frame_trigger_out <= 1'b0;
            o_pattern_adv <= 1'b0;
            grp_cnt_reg <= 8'h00;
        end else begin
            o_pattern_adv <= int_adv;
            if (ext_mode) begin
                o_frame_trigger_out <= fs_edge; // each input frame
            end else if (int_adv) begin
                o_frame_trigger_out <= grp_cnt_reg == 8'h00; // group start
            end else begin
                o_frame_trigger_out <= 1'b0;
            end
            if (int_adv) begin
                grp_cnt_reg <= (grp_cnt_reg == 8'(GROUP_SIZE - 1)) ? 8'h00 : grp_cnt_reg + 8'h01;
            end else if (!int_mode) begin
                grp_cnt_reg <= 8'h00;
            end
        end
    end

    // pattern trigger high while each pattern shows, several per frame
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pat_left_reg <= 5'h00;
            o_pattern_trigger_out <= 1'b0;
        end else if (ext_mode && fs_edge) begin
            pat_left_reg <= i_cfg_pat_per_frame;
            o_pattern_trigger_out <= i_cfg_pat_per_frame != 5'h00;
        end else if (ext_mode && ls_edge && pat_left_reg != 5'h00) begin
            // line syncs alternate: one closes the open pattern slot, the next opens the following one
            o_pattern_trigger_out <= ~o_pattern_trigger_out;
            if (o_pattern_trigger_out) begin
                pat_left_reg <= pat_left_reg - 5'h01;
            end
        end else if (int_mode) begin
            o_pattern_trigger_out <= int_adv ? 1'b1 : (ls_edge ? 1'b0 : o_pattern_trigger_out);
        end else if (!ext_mode) begin
            o_pattern_trigger_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_trig_ignored: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !int_mode |=> !o_pattern_adv) else $error("trigger advanced outside internal mode");
    a_frame_trig_ext: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (ext_mode && fs_edge) |=> o_frame_trigger_out) else $error("no frame trigger on frame");
    a_mask_blocks: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        masked_reg |=> !o_pixel_stb) else $error("masked pixel forwarded");
    a_valid_only: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !take |=> !o_pixel_stb) else $error("pixel without valid sample");
    a_sync_loss: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (loss_cnt_reg == LW'(SYNC_LOSS_CYC)) |=> !o_led_enable) else $error("leds on after sync loss");
    a_frame_rate: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        fs_edge |=> o_frame_start) else $error("frame dropped");
    a_phase_range: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        phase_reg <= ppi_pkg::PPI_SER888_LAST) else $error("serial phase out of range");
    a_line_restart: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (take && line_first_reg) |=> (serial_fmt ? phase_reg <= 2'h1 : 1'b1)) else $error("phase not restarted");
    a_x_bound: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        o_x < 11'(ppi_pkg::PPI_MAX_WIDTH)) else $error("column past max width");
    a_bypass: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        pat_mode |=> o_bypass) else $error("pattern mode not bypassed");
    c_pixel: cover property (@(posedge i_clock) o_pixel_stb);
    c_frame_trig: cover property (@(posedge i_clock) o_frame_trigger_out);
    c_pat_trig: cover property (@(posedge i_clock) o_pattern_trigger_out);
    c_loss: cover property (@(posedge i_clock) $fell(o_seq_run));
endmodule : ppi_port

// ---- test/ppi_src_model.sv ----
// ppi_src_model: host video source driving the parallel pixel pins
`timescale 1ns/1ns
module ppi_src_model (
    // pacing clock
    input wire logic i_clock,
    // source pins
    output logic o_pclk,
    output logic o_fsync,
    output logic o_lsync,
    output logic o_valid,
    output logic [23:0] o_bus,
    output logic o_eye,
    output logic o_mask
);
    // ----------------------------------------
    // idle pins, pixel clock parked between frames
    // ----------------------------------------
    initial begin
        o_pclk = 1'b0;
        o_fsync = 1'b0;
        o_lsync = 1'b0;
        o_valid = 1'b0;
        o_bus = 24'h0;
        o_eye = 1'b1;
        o_mask = 1'b0;
    end
    // wait n clocks, then step just past the edge
    task automatic gap(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : gap
    // frame sync level; eye and mask settle in blanking first
    task automatic fs(input logic l, input logic eye, input logic mask);
        o_eye = eye;
        o_mask = mask;
        gap(16);
        o_fsync = l;
        gap(16); // eye untouched after the edge
    endtask : fs
    // one line sync pulse
    task automatic ls();
        o_lsync = 1'b1;
        gap(16);
        o_lsync = 1'b0;
        gap(16);
    endtask : ls
    // one pixel clock period; bus inverted once released
    task automatic pix(input logic [23:0] d, input logic v);
        o_bus = d;
        o_valid = v;
        gap(4);
        o_pclk = 1'b1;
        gap(8);
        o_pclk = 1'b0;
        gap(3); // data holds past either clock edge
        o_bus = ~d;
        o_valid = 1'b0;
        gap(1);
    endtask : pix
endmodule : ppi_src_model

// ---- test/tb_top.sv ----
// tb_top: self-checking bench for the parallel pixel port
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    typedef struct {
        logic [2:0] fmt;
        int n;
        logic [23:0] w0, w1, w2;
        int ns;
        logic [23:0] px;
    } ppi_row_t;
    logic i_clock, i_sys_rst, i_trigger_in, i_cfg_fsync_fall, i_cfg_mask_low, i_cfg_pclk_fall, i_cfg_lsync_fall;
    logic [4:0] i_cfg_pat_per_frame;
    logic [10:0] o_x, o_y;
    logic o_bypass, o_line_start, o_pattern_trigger_out, pt_d;
    logic i_pixel_clock, i_frame_sync, i_line_sync, i_pixel_valid, i_frame_update_mask, i_eye_select;
    logic [23:0] i_pixel_bus, o_pixel, last_pix;
    logic [2:0] i_cfg_format;
    logic [1:0] i_cfg_mode;
    logic o_pixel_stb, o_frame_start, o_eye_left, o_seq_run, o_led_enable, o_frame_trigger_out, o_pattern_adv;
    int err_total = 0, tests_run = 0, cyc = 0, n_stb = 0, n_fs = 0, n_ft = 0, n_adv = 0, b;
    int n_ls = 0, n_pt = 0, b2, b3;
    // format rows: words in, strobes and last pixel out
    ppi_row_t rows [6] = '{
        '{3'h0, 1, 24'ha5c33c, 24'h0, 24'h0, 1, 24'ha5c33c},
        '{3'h1, 1, 24'hffffff, 24'h0, 24'h0, 1, 24'hfcfcfc},
        '{3'h2, 1, 24'hffffff, 24'h0, 24'h0, 1, 24'hf8fcf8},
        '{3'h3, 2, 24'h00a030, 24'h00b050, 24'h0, 2, 24'hb03050},
        '{3'h4, 3, 24'h11, 24'h22, 24'h33, 1, 24'h112233},
        '{3'h5, 2, 24'h40, 24'h80, 24'h0, 1, 24'h804040}};
    // ----------------------------------------
    // parts
    // ----------------------------------------
    ppi_src_model src (.i_clock(i_clock), .o_pclk(i_pixel_clock), .o_fsync(i_frame_sync),
        .o_lsync(i_line_sync), .o_valid(i_pixel_valid), .o_bus(i_pixel_bus), .o_eye(i_eye_select),
        .o_mask(i_frame_update_mask));
    ppi_port #(.SYNC_LOSS_CYC(200), .GROUP_SIZE(4)) dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_pixel_clock(i_pixel_clock), .i_frame_sync(i_frame_sync), .i_line_sync(i_line_sync),
        .i_pixel_valid(i_pixel_valid), .i_pixel_bus(i_pixel_bus), .i_frame_update_mask(i_frame_update_mask),
        .i_eye_select(i_eye_select), .i_trigger_in(i_trigger_in), .i_cfg_format(i_cfg_format),
        .i_cfg_mode(i_cfg_mode), .i_cfg_pclk_fall(i_cfg_pclk_fall), .i_cfg_fsync_fall(i_cfg_fsync_fall),
        .i_cfg_lsync_fall(i_cfg_lsync_fall), .i_cfg_mask_low(i_cfg_mask_low),
        .i_cfg_pat_per_frame(i_cfg_pat_per_frame),
        .o_pixel(o_pixel), .o_pixel_stb(o_pixel_stb), .o_bypass(o_bypass), .o_frame_start(o_frame_start),
        .o_line_start(o_line_start), .o_eye_left(o_eye_left), .o_x(o_x), .o_y(o_y), .o_seq_run(o_seq_run),
        .o_led_enable(o_led_enable), .o_frame_trigger_out(o_frame_trigger_out),
        .o_pattern_trigger_out(o_pattern_trigger_out), .o_pattern_adv(o_pattern_adv));
    // ----------------------------------------
    // clock, pulse counters and hang guard
    // ----------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        if (o_pixel_stb === 1'b1) begin
            n_stb++;
            last_pix = o_pixel;
        end
        if (o_frame_start === 1'b1) n_fs++;
        if (o_frame_trigger_out === 1'b1) n_ft++;
        if (o_pattern_adv === 1'b1) n_adv++;
        if (o_line_start === 1'b1) n_ls++;
        if (o_pattern_trigger_out === 1'b1 && pt_d !== 1'b1) n_pt++;
        pt_d = o_pattern_trigger_out;
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            give_verdict();
        end
    end
    // value compare
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // frame with one pixel, then the strobe count
    task automatic frame1(input logic mask, input int exp);
        b = n_stb;
        src.fs(1'b1, 1'b0, mask);
        src.fs(1'b0, 1'b0, mask);
        src.pix(24'h5a5a5a, 1'b1);
        src.gap(8);
        chk(24'(n_stb - b), 24'(exp));
    endtask : frame1
    // report counts and end the run
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        i_sys_rst = 1'b1;
        i_trigger_in = 1'b0;
        i_cfg_fsync_fall = 1'b0;
        i_cfg_mask_low = 1'b0;
        i_cfg_format = 3'h0;
        i_cfg_mode = 2'h0;
        i_cfg_pclk_fall = 1'b0;
        i_cfg_lsync_fall = 1'b0;
        i_cfg_pat_per_frame = 5'h1;
        repeat (10) @(posedge i_clock);
        #1 i_sys_rst = 1'b0;
        src.gap(2);
        foreach (rows[i]) begin
            i_cfg_format = rows[i].fmt;
            src.fs(1'b1, 1'b1, 1'b0);
            src.fs(1'b0, 1'b1, 1'b0);
            src.ls();
            b = n_stb;
            src.pix(rows[i].w0, 1'b1);
            if (rows[i].n > 1) src.pix(rows[i].w1, 1'b1);
            if (rows[i].n > 2) src.pix(rows[i].w2, 1'b1);
            src.pix(24'h0f0f0f, 1'b0);
            src.gap(8);
            chk(24'(n_stb - b), 24'(rows[i].ns));
            chk(last_pix, rows[i].px);
            chk(24'(o_eye_left), 24'h1);
            chk(24'(o_x), 24'(rows[i].ns - 1));
            chk(24'(o_bypass), 24'h0);
        end
        i_cfg_format = 3'h0;
        frame1(1'b1, 0);
        i_cfg_mask_low = 1'b1;
        frame1(1'b1, 1);
        frame1(1'b0, 0);
        i_cfg_mask_low = 1'b0;
        chk(24'(o_eye_left), 24'h0);
        chk(24'(o_seq_run), 24'h1);
        // falling pixel clock and line sync edges, pixel on a second line
        i_cfg_pclk_fall = 1'b1;
        i_cfg_lsync_fall = 1'b1;
        src.fs(1'b1, 1'b0, 1'b0);
        src.fs(1'b0, 1'b0, 1'b0);
        b = n_stb;
        b2 = n_ls;
        src.pix(24'h123456, 1'b1);
        src.ls();
        src.pix(24'h654321, 1'b1);
        src.gap(8);
        chk(24'(n_stb - b), 24'h2);
        chk(24'(n_ls - b2), 24'h1);
        chk(last_pix, 24'h654321);
        chk(24'(o_y), 24'h1);
        chk(24'(o_x), 24'h0);
        i_cfg_pclk_fall = 1'b0;
        i_cfg_lsync_fall = 1'b0;
        i_cfg_fsync_fall = 1'b1;
        b = n_fs;
        src.fs(1'b1, 1'b0, 1'b0);
        chk(24'(n_fs - b), 24'h0);
        src.fs(1'b0, 1'b0, 1'b0);
        chk(24'(n_fs - b), 24'h1);
        i_cfg_fsync_fall = 1'b0;
        i_cfg_mode = 2'h1;
        i_cfg_pat_per_frame = 5'h2;
        b = n_ft;
        b2 = n_pt;
        src.fs(1'b1, 1'b0, 1'b0);
        src.fs(1'b0, 1'b0, 1'b0);
        chk(24'(n_ft - b), 24'h1);
        repeat (3) src.ls();
        chk(24'(n_pt - b2), 24'h2);
        chk(24'(o_pattern_trigger_out), 24'h0);
        chk(24'(o_bypass), 24'h1);
        for (int m = 1; m < 3; m++) begin
            i_cfg_mode = 2'(m);
            b = n_adv;
            b2 = n_ft;
            b3 = n_pt;
            i_trigger_in = 1'b1;
            src.gap(8);
            i_trigger_in = 1'b0;
            src.gap(8);
            chk(24'(n_adv - b), 24'(m - 1));
            chk(24'(n_ft - b2), 24'(m - 1));
            chk(24'(n_pt - b3), 24'(m - 1));
        end
        src.gap(250);
        chk(24'(o_seq_run), 24'h0);
        chk(24'(o_led_enable), 24'h0);
        // reset in mid-run clears the trigger and bypass outputs
        i_sys_rst = 1'b1;
        src.gap(2);
        chk(24'(o_pattern_trigger_out), 24'h0);
        chk(24'(o_bypass), 24'h0);
        i_sys_rst = 1'b0;
        src.gap(4);
        chk(24'(o_bypass), 24'h1);
        give_verdict();
    end
endmodule : tb_top
